// [pcep_defines.svh]
// constants for the printer character entry path
// ==========================================================
// Operation
// - flag a key code as invalid when two or more keys are down
// - drop invalid key codes; never hand them to the serialiser
// - with exactly one key down, pass its ascii code to the serialiser
// - serialiser shifts one bit per bit-rate period of PCEP_BIT_CYC system clocks
// - frame with start bit, parity, then one or two stop bits
// - deserialiser takes internal or remote line serial data
// - deserialiser classifies each character as printing or control
// - control characters are not stored; only LF, CR and BEL raise control strobes
// - printing characters are written into character memory
// - column count is stored in column memory with each write
// - bit eight set for printing characters after a pending line feed
// - all clocks derive from one oscillator by digital division
`ifndef PCEP_DEFINES_SVH
`define PCEP_DEFINES_SVH
`define PCEP_OSC_HZ 10000000
`define PCEP_BAUD_HZ 9600
`define PCEP_BIT_CYC (`PCEP_OSC_HZ / `PCEP_BAUD_HZ)
`define PCEP_HALF_CYC (`PCEP_BIT_CYC / 2)
`define PCEP_NKEYS 96
`define PCEP_KEY_BASE 7'h20
`define PCEP_COL_W 7
`define PCEP_MEM_DEPTH 128
`define PCEP_FIFO_DEPTH 16
`define PCEP_CH_LF 7'h0a
`define PCEP_CH_CR 7'h0d
`define PCEP_CH_BEL 7'h07
`define PCEP_CH_DEL 7'h7f
`define PCEP_CH_SP 7'h20
`endif

// [pcep_pkg.sv]
// types for the printer character entry path
package pcep_pkg;
	typedef enum logic [1:0] {
		PCEP_TX_IDLE = 2'b00,
		PCEP_TX_SHIFT = 2'b01,
		PCEP_TX_STOP = 2'b10
	} pcep_tx_t;
	typedef enum logic [1:0] {
		PCEP_RX_IDLE = 2'b00,
		PCEP_RX_START = 2'b01,
		PCEP_RX_DATA = 2'b10,
		PCEP_RX_STOP = 2'b11
	} pcep_rx_t;
endpackage

// [pcep_fifo.sv]
// small valid/ready fifo for incoming characters
module pcep_fifo #(
	parameter int WIDTH = 7,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid_i && (count != (AW+1)'(DEPTH));
	wire pop = out_ready_i && (count != '0);
	assign in_ready_o = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];
	always_ff @(posedge sys_clk_i) begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// [pcep_entry.sv]
// character entry path: keys, serialiser, deserialiser, memory write
`include "pcep_defines.svh"
module pcep_entry (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [`PCEP_NKEYS-1:0] key_down_i,
	input wire logic odd_parity_i,
	input wire logic two_stop_i,
	input wire logic remote_sel_i,
	input wire logic remote_rx_i,
	input wire logic lf_done_i,
	input wire logic mem_ready_i,
	output logic line_tx_o,
	output logic key_invalid_o,
	output logic key_busy_o,
	output logic mem_we_o,
	output logic [7:0] char_data_o,
	output logic [`PCEP_COL_W-1:0] col_data_o,
	output logic [`PCEP_COL_W-1:0] mem_addr_o,
	output logic ctl_lf_o,
	output logic ctl_cr_o,
	output logic ctl_bel_o,
	output logic parity_err_o,
	output logic frame_err_o
);
	import pcep_pkg::*;
	// ==========================================================
	// helpers
	function automatic logic par_bit(input logic [6:0] d, input logic odd);
		par_bit = (^d) ^ odd;
	endfunction
	localparam int BITC = `PCEP_BIT_CYC;
	localparam int HALFC = `PCEP_HALF_CYC;
	// ==========================================================
	// key sense: count pressed keys and encode one
	logic [6:0] key_cnt;
	logic [6:0] key_code;
	always_comb begin
		key_cnt = '0;
		key_code = '0;
		for (int i = 0; i < `PCEP_NKEYS; i++) begin
			if (key_down_i[i]) begin
				key_cnt = key_cnt + 7'h01;
				key_code = `PCEP_KEY_BASE + 7'(i);
			end
		end
	end
	wire multi_key = key_cnt > 7'h01;
	wire one_key = key_cnt == 7'h01;
	logic key_held;
	// a held key sends once; release re-arms
	wire key_take = one_key && !key_held && !key_busy_o;
	logic [6:0] tx_hold;
	logic tx_pend;
	pcep_tx_t tx_st;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			key_held <= 1'b0;
			key_invalid_o <= 1'b0;
			tx_hold <= '0;
			tx_pend <= 1'b0;
		end else begin
			key_invalid_o <= multi_key;
			if (key_cnt == 7'h00)
				key_held <= 1'b0;
			else if (key_take || multi_key)
				key_held <= 1'b1;
			if (key_take) begin
				tx_hold <= key_code;
				tx_pend <= 1'b1;
			end else if (tx_st == PCEP_TX_IDLE && tx_pend)
				tx_pend <= 1'b0;
		end
	end
	// ==========================================================
	// serialiser, bit timer divided from the system clock
	logic [15:0] tx_tmr;
	logic [3:0] tx_idx;
	logic [8:0] tx_sh;
	wire tx_tick = tx_tmr == 16'(BITC - 1);
	wire [3:0] tx_stops = two_stop_i ? 4'h2 : 4'h1;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tx_st <= PCEP_TX_IDLE;
			tx_tmr <= '0;
			tx_idx <= '0;
			tx_sh <= '1;
			line_tx_o <= 1'b1;
			key_busy_o <= 1'b0;
		end else begin
			key_busy_o <= tx_pend || tx_st != PCEP_TX_IDLE;
			tx_tmr <= (tx_st == PCEP_TX_IDLE || tx_tick) ? '0 : tx_tmr + 16'h0001;
			unique case (tx_st)
				PCEP_TX_IDLE: begin
					if (tx_pend) begin
						// start bit, then data lsb first, then parity
						line_tx_o <= 1'b0;
						tx_sh <= {par_bit(tx_hold, odd_parity_i), tx_hold};
						tx_idx <= '0;
						tx_st <= PCEP_TX_SHIFT;
					end
				end
				PCEP_TX_SHIFT: begin
					if (tx_tick) begin
						line_tx_o <= (tx_idx == 4'h8) ? 1'b1 : tx_sh[0];
						tx_sh <= {1'b1, tx_sh[8:1]};
						tx_idx <= tx_idx + 4'h1;
						if (tx_idx == 4'h8) begin
							tx_idx <= '0;
							tx_st <= PCEP_TX_STOP;
						end
					end
				end
				PCEP_TX_STOP: begin
					if (tx_tick) begin
						tx_idx <= tx_idx + 4'h1;
						if (tx_idx + 4'h1 == tx_stops)
							tx_st <= PCEP_TX_IDLE;
					end
				end
				default: tx_st <= PCEP_TX_IDLE;
			endcase
		end
	end
	// ==========================================================
	// deserialiser, source is keyboard loop or remote line
	wire rx_line = remote_sel_i ? remote_rx_i : line_tx_o;
	pcep_rx_t rx_st;
	logic [15:0] rx_tmr;
	logic [3:0] rx_idx;
	logic [7:0] rx_sh;
	logic fifo_ready;
	logic rx_push;
	logic [6:0] rx_char;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rx_st <= PCEP_RX_IDLE;
			rx_tmr <= '0;
			rx_idx <= '0;
			rx_sh <= '0;
			rx_push <= 1'b0;
			rx_char <= '0;
			parity_err_o <= 1'b0;
			frame_err_o <= 1'b0;
		end else begin
			rx_push <= rx_push && !fifo_ready;
			rx_tmr <= rx_tmr + 16'h0001;
			unique case (rx_st)
				PCEP_RX_IDLE: begin
					rx_tmr <= '0;
					if (!rx_line)
						rx_st <= PCEP_RX_START;
				end
				PCEP_RX_START: begin
					if (rx_tmr == 16'(HALFC - 1)) begin
						rx_tmr <= '0;
						rx_idx <= '0;
						rx_st <= rx_line ? PCEP_RX_IDLE : PCEP_RX_DATA;
					end
				end
				PCEP_RX_DATA: begin
					if (rx_tmr == 16'(BITC - 1)) begin
						rx_tmr <= '0;
						rx_sh <= {rx_line, rx_sh[7:1]};
						rx_idx <= rx_idx + 4'h1;
						if (rx_idx == 4'h7)
							rx_st <= PCEP_RX_STOP;
					end
				end
				PCEP_RX_STOP: begin
					if (rx_tmr == 16'(BITC - 1)) begin
						rx_st <= PCEP_RX_IDLE;
						frame_err_o <= !rx_line;
						parity_err_o <= rx_sh[7] != par_bit(rx_sh[6:0], odd_parity_i);
						if (rx_line && rx_sh[7] == par_bit(rx_sh[6:0], odd_parity_i)) begin
							rx_push <= 1'b1;
							rx_char <= rx_sh[6:0];
						end
					end
				end
				default: rx_st <= PCEP_RX_IDLE;
			endcase
		end
	end
	// ==========================================================
	// buffer between line and memory; memory stalls hold characters in it
	logic q_valid;
	logic [6:0] q_char;
	wire q_take = q_valid && mem_ready_i;
	pcep_fifo #(.WIDTH(7), .DEPTH(`PCEP_FIFO_DEPTH)) u_fifo (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.in_valid_i(rx_push),
		.in_ready_o(fifo_ready),
		.in_data_i(rx_char),
		.out_valid_o(q_valid),
		.out_ready_i(mem_ready_i),
		.out_data_o(q_char)
	);
	// ==========================================================
	// classify and enter
	wire is_ctrl = (q_char < `PCEP_CH_SP) || (q_char == `PCEP_CH_DEL);
	logic lf_pend;
	logic [`PCEP_COL_W-1:0] col_cnt;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			lf_pend <= 1'b0;
			col_cnt <= '0;
			mem_we_o <= 1'b0;
			char_data_o <= '0;
			col_data_o <= '0;
			mem_addr_o <= '0;
			ctl_lf_o <= 1'b0;
			ctl_cr_o <= 1'b0;
			ctl_bel_o <= 1'b0;
		end else begin
			mem_we_o <= q_take && !is_ctrl;
			ctl_lf_o <= q_take && q_char == `PCEP_CH_LF;
			ctl_cr_o <= q_take && q_char == `PCEP_CH_CR;
			ctl_bel_o <= q_take && q_char == `PCEP_CH_BEL;
			// set wins over the done clear
			if (q_take && q_char == `PCEP_CH_LF)
				lf_pend <= 1'b1;
			else if (lf_done_i)
				lf_pend <= 1'b0;
			if (q_take && q_char == `PCEP_CH_CR)
				col_cnt <= '0;
			if (q_take && !is_ctrl) begin
				char_data_o <= {lf_pend, q_char};
				col_data_o <= col_cnt;
				mem_addr_o <= col_cnt;
				col_cnt <= col_cnt + 1'b1;
			end
		end
	end
	// ==========================================================
	// checks
	a_multi_blocked: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		multi_key |-> !key_take) else $error("multi key sent");
	a_invalid_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		multi_key |=> key_invalid_o) else $error("invalid not flagged");
	a_key_loaded: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		key_take |=> tx_pend && tx_hold == $past(key_code)) else $error("key lost");
	a_start_bit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		tx_st == PCEP_TX_IDLE && tx_pend |=> !line_tx_o) else $error("no start");
	a_bit_period: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		tx_st == PCEP_TX_SHIFT && !tx_tick |=> $stable(line_tx_o)) else $error("bit glitch");
	a_ctrl_nostore: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		q_take && is_ctrl |=> !mem_we_o) else $error("control stored");
	a_print_store: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		q_take && !is_ctrl |=> mem_we_o && char_data_o[6:0] == $past(q_char)) else $error("print lost");
	a_col_store: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		q_take && !is_ctrl |=> col_data_o == $past(col_cnt)) else $error("column wrong");
	a_lf_bit8: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		q_take && !is_ctrl |=> char_data_o[7] == $past(lf_pend)) else $error("bit8 wrong");
	a_col_incr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		q_take && !is_ctrl |=> col_cnt == $past(col_cnt) + 1'b1) else $error("col stuck");
	c_key_sent: cover property (@(posedge sys_clk_i) key_take);
	c_multi: cover property (@(posedge sys_clk_i) multi_key);
	c_print: cover property (@(posedge sys_clk_i) mem_we_o && char_data_o[7]);
	c_lf: cover property (@(posedge sys_clk_i) ctl_lf_o);
endmodule

// [pcep_remote_model.sv]
// remote terminal model: frames characters onto its serial line
`include "pcep_defines.svh"
module pcep_remote_model (
	input wire logic sys_clk_i,
	output logic line_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// line rests marking between frames, as a real terminal does
	initial line_o = 1'b1;
	task automatic send(input logic [6:0] ch, input logic odd,
		input logic two, input logic bad_par);
		logic [10:0] fr;
		int n;
		fr = {2'b11, (^ch) ^ odd ^ bad_par, ch, 1'b0};
		n = two ? 11 : 10;
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk_i);
			line_o <= fr[i];
			repeat (`PCEP_BIT_CYC - 1) @(posedge sys_clk_i);
		end
	endtask
endmodule

// [printer_character_entry_path_tb.sv]
// self-checking bench for the printer character entry path
`include "pcep_defines.svh"
module printer_character_entry_path_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [`PCEP_NKEYS-1:0] key_down = '0;
	logic odd_par = 1'b0;
	logic two_stop = 1'b0;
	logic remote_sel = 1'b0;
	logic lf_done = 1'b0;
	logic mem_ready = 1'b1;
	logic remote_line, line_tx, key_invalid, key_busy, mem_we;
	logic ctl_lf, ctl_cr, ctl_bel, parity_err, frame_err;
	logic [7:0] char_data;
	logic [7:0] last_char;
	logic [`PCEP_COL_W-1:0] col_data, mem_addr, last_col, last_addr;
	int n_cr = 0;
	int n_bel = 0;
	logic [9:0] fr;
	int n_mismatch = 0;
	int tests_run = 0;
	int n_wr = 0;
	int n_lf = 0;
	int n;
	// ==========================================================
	// clock, design and remote terminal
	always #50 sys_clk_i = ~sys_clk_i;
	pcep_entry dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.key_down_i(key_down), .odd_parity_i(odd_par),
		.two_stop_i(two_stop), .remote_sel_i(remote_sel),
		.remote_rx_i(remote_line), .lf_done_i(lf_done),
		.mem_ready_i(mem_ready), .line_tx_o(line_tx),
		.key_invalid_o(key_invalid), .key_busy_o(key_busy),
		.mem_we_o(mem_we), .char_data_o(char_data),
		.col_data_o(col_data), .mem_addr_o(mem_addr), .ctl_lf_o(ctl_lf),
		.ctl_cr_o(ctl_cr), .ctl_bel_o(ctl_bel),
		.parity_err_o(parity_err), .frame_err_o(frame_err));
	pcep_remote_model remote (.sys_clk_i(sys_clk_i), .line_o(remote_line));
	// ==========================================================
	// write and control strobe monitor
	always @(posedge sys_clk_i) begin
		if (mem_we === 1'b1) begin
			n_wr <= n_wr + 1;
			last_char <= char_data;
			last_col <= col_data;
			last_addr <= mem_addr;
		end
		if (ctl_lf === 1'b1) begin
			n_lf <= n_lf + 1;
		end
		if (ctl_cr === 1'b1) begin
			n_cr <= n_cr + 1;
		end
		if (ctl_bel === 1'b1) begin
			n_bel <= n_bel + 1;
		end
	end
	// ==========================================================
	// shared helpers
	task automatic end_sim();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// bounded wait on the write or line feed count
	task automatic wait_ev(input bit lf, input int target, input int lim);
		int k;
		k = 0;
		while ((lf ? n_lf : n_wr) < target && k < lim) begin
			@(posedge sys_clk_i);
			k++;
		end
		if ((lf ? n_lf : n_wr) < target) begin
			n_mismatch++;
			$display("[ERR] event count expected %0d seen short", target);
			end_sim();
		end
	endtask
	// ==========================================================
	// scenarios
	task automatic t_multi_key();
		@(posedge sys_clk_i);
		key_down <= 96'h0000_0000_0000_0006_0000_0000;
		repeat (10) @(posedge sys_clk_i);
		#1;
		check("key_invalid", 16'h0001, {15'h0000, key_invalid});
		check("key_busy", 16'h0000, {15'h0000, key_busy});
		check("line_tx", 16'h0001, {15'h0000, line_tx});
		@(posedge sys_clk_i);
		key_down <= '0;
		repeat (3) @(posedge sys_clk_i);
	endtask
	// one key looped back through the deserialiser
	task automatic t_key_loop();
		fr = {1'b1, 1'b0, 7'h41, 1'b0};
		@(posedge sys_clk_i);
		key_down <= 96'h0000_0000_0000_0002_0000_0000;
		n = 0;
		while (line_tx !== 1'b0 && n < 10) begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
		check("take to start bit", 16'h0002, n[15:0]);
		check("key_busy", 16'h0001, {15'h0000, key_busy});
		@(posedge sys_clk_i);
		key_down <= '0;
		repeat (`PCEP_HALF_CYC - 1) @(posedge sys_clk_i);
		#1;
		check("frame bit 0", 16'h0000, {15'h0000, line_tx});
		for (int i = 1; i < 10; i++) begin
			repeat (`PCEP_BIT_CYC) @(posedge sys_clk_i);
			#1;
			check("frame bit", {15'h0000, fr[i]}, {15'h0000, line_tx});
		end
		wait_ev(1'b0, 1, 2 * `PCEP_BIT_CYC);
		check("char", 16'h0041, {8'h00, last_char});
		check("column", 16'h0000, {9'h000, last_col});
	endtask
	// remote traffic, odd parity, two stops, line feed pending
	task automatic t_remote();
		@(posedge sys_clk_i);
		remote_sel <= 1'b1;
		odd_par <= 1'b1;
		two_stop <= 1'b1;
		remote.send(7'h42, 1'b1, 1'b1, 1'b0);
		wait_ev(1'b0, 2, 20);
		check("char", 16'h0042, {8'h00, last_char});
		check("column", 16'h0001, {9'h000, last_col});
		remote.send(`PCEP_CH_LF, 1'b1, 1'b1, 1'b0);
		wait_ev(1'b1, 1, 20);
		check("writes after lf", 16'h0002, n_wr[15:0]);
		@(posedge sys_clk_i);
		mem_ready <= 1'b0;
		remote.send(7'h43, 1'b1, 1'b1, 1'b0);
		repeat (20) @(posedge sys_clk_i);
		check("stalled writes", 16'h0002, n_wr[15:0]);
		mem_ready <= 1'b1;
		wait_ev(1'b0, 3, 20);
		check("char after lf", 16'h00c3, {8'h00, last_char});
		check("column", 16'h0002, {9'h000, last_col});
		// bad parity must be flagged and dropped
		remote.send(7'h44, 1'b1, 1'b1, 1'b1);
		repeat (20) @(posedge sys_clk_i);
		#1;
		check("parity_err", 16'h0001, {15'h0000, parity_err});
		check("writes", 16'h0003, n_wr[15:0]);
	endtask
	// one stop bit, carriage return, then line feed done
	task automatic t_ctrl();
		@(posedge sys_clk_i);
		two_stop <= 1'b0;
		remote.send(`PCEP_CH_CR, 1'b1, 1'b0, 1'b0);
		repeat (20) @(posedge sys_clk_i);
		check("cr strobes", 16'h0001, n_cr[15:0]);
		check("writes after cr", 16'h0003, n_wr[15:0]);
		lf_done <= 1'b1;
		@(posedge sys_clk_i);
		lf_done <= 1'b0;
		remote.send(7'h45, 1'b1, 1'b0, 1'b0);
		wait_ev(1'b0, 4, 20);
		check("char lf done", 16'h0045, {8'h00, last_char});
		check("column cr", 16'h0000, {9'h000, last_col});
		check("address", 16'h0000, {9'h000, last_addr});
		#1;
		check("parity_err", 16'h0000, {15'h0000, parity_err});
		check("frame_err", 16'h0000, {15'h0000, frame_err});
		check("bel strobes", 16'h0000, n_bel[15:0]);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		t_multi_key();
		t_key_loop();
		t_remote();
		t_ctrl();
		end_sim();
	end
endmodule
